// ==== core/adc_regs_pkg.sv ====
// Constants for the converter register bank: select codes, widths,
// reset values and bit positions.
// Assumes the host drives a framed serial link clocked by the host.
`default_nettype none

package adc_regs_pkg;
   localparam logic [2:0] RS_DATA = 3'h3;
   localparam logic [2:0] RS_ID = 3'h4;
   localparam logic [2:0] RS_GPO = 3'h5;
   localparam int DATA_W = 24;
   localparam int BYTE_W = 8;
   localparam int FRAME_W = 32;
   localparam logic [23:0] DATA_RST = 24'h000000;
   localparam logic [7:0] GPO_RST = 8'h00;
   localparam logic [7:0] GPO_WMASK = 8'h3f;
   localparam int GPO_UPPER_EN = 5;
   localparam int GPO_LOWER_EN = 4;
   localparam int CMD_RW_BIT = 6;
   localparam int CMD_RS_HI = 5;
   localparam int CMD_RS_LO = 3;
   localparam logic [5:0] LEN_DATA = 6'h18;
   localparam logic [5:0] LEN_DATA_STA = 6'h20;
   localparam logic [5:0] LEN_BYTE = 6'h08;
endpackage : adc_regs_pkg

`default_nettype wire

// ==== core/link_sampler.sv ====
// Two-flop synchroniser for a group of pin inputs, with edge pulses.
// Assumes every input is asynchronous to i_clk.
`default_nettype none

module link_sampler #(
   parameter int W = 7
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync,
   output logic [W-1:0] o_rise,
   output logic [W-1:0] o_fall
);
   logic [W-1:0] meta_r;
   logic [W-1:0] sync_r;
   logic [W-1:0] prev_r;

   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         // Edges are taken from the second stage only
         always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
               meta_r[g] <= 1'b1;
               sync_r[g] <= 1'b1;
               prev_r[g] <= 1'b1;
            end else begin
               meta_r[g] <= i_async[g];
               sync_r[g] <= meta_r[g];
               prev_r[g] <= sync_r[g];
            end
         end
      end
   endgenerate

   assign o_sync = sync_r;
   assign o_rise = sync_r & ~prev_r;
   assign o_fall = ~sync_r & prev_r;
endmodule : link_sampler

`default_nettype wire

// ==== core/adc_channel_regs.sv ====
// Result, identification and output control registers of the converter,
// with channel routing and the host serial link.
// Assumes host samples i_dout on rising link clock; frames on i_cs_n low.
`default_nettype none

module adc_channel_regs #(
   parameter logic [7:0] ID_CODE = 8'h5a // Arbitrary value
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_sclk,
   input wire logic i_cs_n,
   input wire logic i_din,
   output logic o_dout,
   output logic o_rdy_n,
   input wire logic i_conv_valid,
   input wire logic [23:0] i_conv_data,
   input wire logic [7:0] i_channel_enable,
   input wire logic i_pseudo_sel,
   input wire logic i_append_status_enable,
   output logic [3:0] o_pos_input_sel,
   output logic [3:0] o_neg_input_sel,
   output logic o_neg_is_common,
   input wire logic [3:0] i_gp_pin,
   output logic [3:0] o_gp_out,
   output logic [3:0] o_gp_oe,
   output logic o_upper_pair_analog
);
   typedef enum logic [2:0] {
      ST_CMD = 3'b001,
      ST_READ = 3'b010,
      ST_WRITE = 3'b100
   } link_state_t;

   link_state_t state_r;
   link_state_t state_nxt;
   logic [6:0] s_sync;
   logic [6:0] s_rise;
   logic [7:0] cmd_r;
   logic [5:0] cnt_r;
   logic [5:0] len_r;
   logic [2:0] rs_r;
   logic [31:0] out_r;
   logic [23:0] data_r;
   logic [3:0] tag_r;
   logic rdy_n_r;
   logic [7:0] gpo_r;
   logic [3:0] pos_r;
   logic [3:0] neg_r;
   logic com_r;

   link_sampler #(.W(7)) u_sampler (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_async({i_gp_pin, i_din, i_cs_n, i_sclk}),
      .o_sync(s_sync),
      .o_rise(s_rise),
      .o_fall()
   );

   wire cs_n_s = s_sync[1];
   wire din_s = s_sync[2];
   wire [3:0] gp_s = s_sync[6:3];
   wire bit_tick = s_rise[0] & ~cs_n_s;
   wire [7:0] cmd_full = {cmd_r[6:0], din_s};
   wire last_bit = (cnt_r == len_r - 6'h01);
   wire cmd_done = (state_r == ST_CMD) && bit_tick && (cnt_r == 6'h07);
   wire cmd_rd = cmd_full[adc_regs_pkg::CMD_RW_BIT];
   wire [2:0] cmd_rs =
      cmd_full[adc_regs_pkg::CMD_RS_HI:adc_regs_pkg::CMD_RS_LO];
   wire rd_done = (state_r == ST_READ) && bit_tick && last_bit;
   wire data_rd_done = rd_done && (rs_r == adc_regs_pkg::RS_DATA);
   wire wr_done = (state_r == ST_WRITE) && bit_tick && last_bit;
   wire upper_en = gpo_r[adc_regs_pkg::GPO_UPPER_EN];
   wire lower_en = gpo_r[adc_regs_pkg::GPO_LOWER_EN];

   // Status byte: not-ready in bit 7, channel tag in the low nibble
   wire [7:0] status_byte = {rdy_n_r, 3'h0, tag_r};
   // Value bits read back the pin itself while its pair drives
   wire [7:0] gpo_rd = {gpo_r[7:4],
      upper_en ? gp_s[3:2] : gpo_r[3:2],
      lower_en ? gp_s[1:0] : gpo_r[1:0]};

   // Read frames are left-justified so bit 31 always leaves first
   wire [31:0] load_val =
      (cmd_rs == adc_regs_pkg::RS_DATA) ?
         {data_r, status_byte} :
      (cmd_rs == adc_regs_pkg::RS_ID) ? {ID_CODE, 24'h000000} :
      (cmd_rs == adc_regs_pkg::RS_GPO) ? {gpo_rd, 24'h000000} :
      32'h00000000;
   wire [5:0] load_len =
      (cmd_rs != adc_regs_pkg::RS_DATA) ? adc_regs_pkg::LEN_BYTE :
      i_append_status_enable ? adc_regs_pkg::LEN_DATA_STA :
      adc_regs_pkg::LEN_DATA;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_CMD: begin
            if (cmd_done) begin
               state_nxt = cmd_rd ? ST_READ : ST_WRITE;
            end
         end
         ST_READ: begin
            if (rd_done) begin
               state_nxt = ST_CMD;
            end
         end
         ST_WRITE: begin
            if (wr_done) begin
               state_nxt = ST_CMD;
            end
         end
         default: state_nxt = ST_CMD;
      endcase
      if (cs_n_s) begin
         state_nxt = ST_CMD;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_r <= ST_CMD;
         cnt_r <= 6'h00;
      end else begin
         state_r <= state_nxt;
         if (cs_n_s || cmd_done || rd_done || wr_done) begin
            cnt_r <= 6'h00;
         end else if (bit_tick) begin
            cnt_r <= cnt_r + 6'h01;
         end
      end
   end

   // Command byte in, write data shares the same shifter
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cmd_r <= 8'h00;
         rs_r <= 3'h0;
         len_r <= adc_regs_pkg::LEN_BYTE;
      end else if (bit_tick && state_r != ST_READ) begin
         cmd_r <= cmd_full;
         if (cmd_done) begin
            rs_r <= cmd_rs;
            len_r <= cmd_rd ? load_len : adc_regs_pkg::LEN_BYTE;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         out_r <= 32'h00000000;
      end else if (cmd_done && cmd_rd) begin
         out_r <= load_val;
      end else if (state_r == ST_READ && bit_tick) begin
         out_r <= {out_r[30:0], 1'b0};
      end
   end

   // A new conversion in the same cycle as a finished read wins
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         data_r <= adc_regs_pkg::DATA_RST;
         tag_r <= 4'h0;
         rdy_n_r <= 1'b1;
      end else if (i_conv_valid) begin
         data_r <= i_conv_data;
         tag_r <= i_channel_enable[7:4];
         rdy_n_r <= 1'b0;
      end else if (data_rd_done) begin
         rdy_n_r <= 1'b1;
      end
   end

   // Top two bits stay zero whatever the host sends
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         gpo_r <= adc_regs_pkg::GPO_RST;
      end else if (wr_done && rs_r == adc_regs_pkg::RS_GPO) begin
         gpo_r <= cmd_full & adc_regs_pkg::GPO_WMASK;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pos_r <= 4'h0;
         neg_r <= 4'h0;
         com_r <= 1'b0;
      end else begin
         pos_r <= i_channel_enable[7:4];
         neg_r <= i_pseudo_sel ? 4'h0 : i_channel_enable[3:0];
         com_r <= i_pseudo_sel;
      end
   end

   assign o_dout = out_r[31];
   assign o_rdy_n = rdy_n_r;
   assign o_pos_input_sel = pos_r;
   assign o_neg_input_sel = neg_r;
   assign o_neg_is_common = com_r;
   assign o_gp_out = gpo_r[3:0];
   assign o_gp_oe = {upper_en, upper_en, lower_en, lower_en};
   assign o_upper_pair_analog = ~upper_en;

   a_neg_route: assert property (@(posedge i_clk) disable iff (i_rst)
      !i_pseudo_sel |=> o_neg_input_sel == $past(i_channel_enable[3:0])
         && !o_neg_is_common)
      else $error("negative input not routed from low enable bits");
   a_pseudo_common: assert property (@(posedge i_clk)
      disable iff (i_rst)
      i_pseudo_sel |=> o_neg_is_common && o_neg_input_sel == 4'h0
         && o_pos_input_sel == $past(i_channel_enable[7:4]))
      else $error("pseudo mode routing wrong");
   a_read_sets_rdy: assert property (@(posedge i_clk)
      disable iff (i_rst)
      data_rd_done && !i_conv_valid |=> o_rdy_n)
      else $error("not-ready not set after result read");
   a_conv_ready: assert property (@(posedge i_clk) disable iff (i_rst)
      i_conv_valid |=> !o_rdy_n ##0 data_r == $past(i_conv_data)
         ##0 tag_r == $past(i_channel_enable[7:4]))
      else $error("conversion not captured");
   a_append_len: assert property (@(posedge i_clk) disable iff (i_rst)
      cmd_done && cmd_rd && cmd_rs == adc_regs_pkg::RS_DATA |=>
         len_r == ($past(i_append_status_enable) ? 6'h20 : 6'h18)
         && out_r[3:0] == tag_r)
      else $error("result frame length or tag wrong");
   a_id_load: assert property (@(posedge i_clk) disable iff (i_rst)
      cmd_done && cmd_rd && cmd_rs == adc_regs_pkg::RS_ID |=>
         out_r[31:24] == ID_CODE && len_r == 6'h08)
      else $error("identification not loaded");
   a_gpo_write: assert property (@(posedge i_clk) disable iff (i_rst)
      wr_done && rs_r == adc_regs_pkg::RS_GPO |=>
         gpo_r == ($past(cmd_full) & 8'h3f) && gpo_r[7:6] == 2'h0)
      else $error("output control write wrong");
   a_pair_enables: assert property (@(posedge i_clk)
      disable iff (i_rst)
      o_gp_oe == {gpo_r[5], gpo_r[5], gpo_r[4], gpo_r[4]}
         && o_upper_pair_analog == !gpo_r[5])
      else $error("pin pair enables wrong");
   a_msb_first: assert property (@(posedge i_clk) disable iff (i_rst)
      state_r == ST_READ && bit_tick && !last_bit |=>
         o_dout == $past(out_r[30]))
      else $error("serial output not msb first");
endmodule : adc_channel_regs

`default_nettype wire

// ==== test/host_link_model.sv ====
// Host end of the serial link: one frame per call, command then data.
// Assumes the device takes din on rising link clock; idle clock is high.
`default_nettype none

module host_link_model (
   output logic o_sclk,
   output logic o_cs_n,
   output logic o_din,
   input wire logic i_dout
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      o_sclk = 1'b1;
      o_cs_n = 1'b1;
      o_din = 1'b1;
   end

   // Write data sits left-aligned in w; read data lands right-aligned
   task automatic xfer(input logic [7:0] cmd, input int n,
                       input logic [31:0] w, output logic [31:0] r);
      logic [39:0] bits;
      bits = {cmd, w};
      if (cmd[6] == 1'b0 && cmd[5:3] == 3'h5) begin
         bits[31:30] = 2'b00;
      end
      r = '0;
      o_cs_n = 1'b0;
      #80;
      for (int k = 0; k < 8 + n; k++) begin
         o_sclk = 1'b0;
         o_din = bits[39-k];
         #80;
         o_sclk = 1'b1;
         if (k >= 8) begin
            r = {r[30:0], i_dout};
         end
         #80;
      end
      o_cs_n = 1'b1;
      // Released line shows the inverse so a stale bit cannot pass
      o_din = ~o_din;
      #80;
   endtask : xfer
endmodule : host_link_model

`default_nettype wire

// ==== test/testbench.sv ====
// Self-checking bench of the converter register bank.
// Assumes the host model drives the link; pin levels are modelled here.
`default_nettype none

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] ID_VAL = 8'hc6; // Arbitrary value
   typedef struct packed {
      logic [7:0] en;
      logic pseudo;
      logic [8:0] exp;
   } row_t;
   localparam row_t ROWS [7] = '{'{8'h00, 1'b0, 9'h000},
      '{8'h5f, 1'b0, 9'h05f}, '{8'hf0, 1'b0, 9'h0f0},
      '{8'h00, 1'b1, 9'h100}, '{8'h0f, 1'b1, 9'h100},
      '{8'hfa, 1'b1, 9'h1f0}, '{8'h7c, 1'b1, 9'h170}};
   logic clk, rst, sclk, cs_n, din, dout, rdy_n, conv_valid, pseudo, append;
   logic neg_common, upper_analog;
   logic [23:0] conv_data;
   logic [7:0] chan_en;
   logic [3:0] pos_sel, neg_sel, gp_out, gp_oe, ext_level, pin_fault;
   logic [31:0] rd;
   wire logic [3:0] gp_pin;
   int n_mismatch = 0;
   int checks_done = 0;

   // Driven pins may be pulled off their value by a fault on the board
   assign gp_pin = (gp_oe & (gp_out ^ pin_fault)) | (~gp_oe & ext_level);

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   host_link_model i_host_link_model (.o_sclk(sclk), .o_cs_n(cs_n),
      .o_din(din), .i_dout(dout));
   adc_channel_regs #(.ID_CODE(ID_VAL)) i_adc_channel_regs (.i_clk(clk),
      .i_rst(rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_din(din),
      .o_dout(dout), .o_rdy_n(rdy_n), .i_conv_valid(conv_valid),
      .i_conv_data(conv_data), .i_channel_enable(chan_en),
      .i_pseudo_sel(pseudo), .i_append_status_enable(append),
      .o_pos_input_sel(pos_sel), .o_neg_input_sel(neg_sel),
      .o_neg_is_common(neg_common), .i_gp_pin(gp_pin), .o_gp_out(gp_out),
      .o_gp_oe(gp_oe), .o_upper_pair_analog(upper_analog));

   task automatic cmp_word(input logic [31:0] got, exp, input string s);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: %s got %h want %h", $time, s, got, exp);
      end
   endtask : cmp_word

   task automatic cmp_pins(input logic [9:0] exp, input string s);
      checks_done++;
      if ({rdy_n, upper_analog, gp_oe, gp_out} !== exp) begin
         n_mismatch++;
         $display("Error at %0t: %s pins want %h", $time, s, exp);
      end
   endtask : cmp_pins

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : give_verdict

   task automatic link(input logic [7:0] cmd, input int n,
                       input logic [31:0] w);
      i_host_link_model.xfer(cmd, n, w, rd);
      @(posedge clk);
      #1;
   endtask : link

   task automatic convert(input logic [7:0] en, input logic [23:0] d);
      @(posedge clk);
      chan_en <= en;
      conv_data <= d;
      conv_valid <= 1'b1;
      @(posedge clk);
      conv_valid <= 1'b0;
      for (int k = 0; k < 8; k++) begin
         @(posedge clk);
         #1;
         if (rdy_n === 1'b0) return;
      end
      n_mismatch++;
      give_verdict();
   endtask : convert

   initial begin
      #500us;
      n_mismatch++;
      give_verdict();
   end

   initial begin
      {rst, conv_valid, pseudo, append} = 4'h8;
      {conv_data, chan_en, ext_level, pin_fault} = '0;
      ext_level = 4'h5;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      for (int r = 0; r < 7; r++) begin
         @(posedge clk);
         chan_en <= ROWS[r].en;
         pseudo <= ROWS[r].pseudo;
         repeat (3) @(posedge clk);
         #1;
         cmp_word({neg_common, pos_sel, neg_sel}, ROWS[r].exp,
            "route");
      end
      cmp_pins(10'h300, "reset");
      link(8'h58, 24, 32'h0);
      cmp_word(rd, 32'h0, "result reset");
      link(8'h60, 8, 32'h0);
      cmp_word(rd, {24'h0, ID_VAL}, "ident");
      link(8'h20, 8, 32'h3f000000);
      link(8'h60, 8, 32'h0);
      cmp_word(rd, {24'h0, ID_VAL}, "ident kept");
      link(8'h68, 8, 32'h0);
      cmp_word(rd, 32'h0, "control reset");
      link(8'h78, 8, 32'h0);
      cmp_word(rd, 32'h0, "unmapped");
      pin_fault = 4'h6;
      link(8'h28, 8, 32'hfa000000);
      cmp_pins(10'h2fa, "both pairs");
      link(8'h68, 8, 32'h0);
      cmp_word(rd, 32'h3c, "pin readback");
      pin_fault = 4'h0;
      link(8'h28, 8, 32'h2c000000);
      cmp_pins(10'h2cc, "upper pair");
      link(8'h68, 8, 32'h0);
      // Lower pair is off, so its bits must read the register, not the pins
      cmp_word(rd, 32'h2c, "upper readback");
      convert(8'h93, 24'ha5c3e1);
      link(8'h58, 24, 32'h0);
      cmp_word(rd, 32'ha5c3e1, "result");
      cmp_word({31'h0, rdy_n}, 32'h1, "not ready");
      @(posedge clk);
      append <= 1'b1;
      convert(8'h3c, 24'h1e2d4b);
      link(8'h58, 32, 32'h0);
      cmp_word(rd, 32'h1e2d4b03, "status");
      cmp_word({31'h0, rdy_n}, 32'h1, "not ready");
      // Reset in mid-run, with the upper pair of pins still configured
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      cmp_pins(10'h300, "reset again");
      link(8'h58, 32, 32'h0);
      cmp_word(rd, 32'h80, "result after reset");
      give_verdict();
   end
endmodule : testbench

`default_nettype wire
